// ---- verilog/mtil_top.sv ----
// Material tracking, lighting state, index lighting and colour clamp
`timescale 1ns/1ps
`include "mtil_defs.svh"
module mtil_top
  import mtil_pkg::*;
#(
  parameter int NLIGHTS = 8,
  parameter int IDX_BITS = 8,
  parameter int IDX_FRAC = 4,
  parameter bit FIXED_BUFFER = 1'b1
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Current colour from the vertex pipeline
  input wire logic color_valid,
  input wire logic [63:0] color_rgba,
  // Per-vertex lighting terms
  input wire logic vtx_valid,
  input wire logic [NLIGHTS*16-1:0] att_spot,
  input wire logic [NLIGHTS*16-1:0] n_dot_vp,
  input wire logic [NLIGHTS*16-1:0] n_dot_h_pow_front,
  input wire logic [NLIGHTS*16-1:0] n_dot_h_pow_back,
  input wire logic [63:0] lit_primary,
  input wire logic [63:0] lit_secondary,
  // Results to rasterisation
  output logic out_valid,
  output logic [63:0] out_primary,
  output logic [63:0] out_secondary,
  output logic [IDX_BITS+IDX_FRAC-1:0] out_index_front,
  output logic [IDX_BITS+IDX_FRAC-1:0] out_index_back,
  output logic [511:0] material_q,
  output logic lighting_on,
  output logic index_mode
);

  // Address phase capture; no wait states
  logic dp_wr_r;
  logic [11:0] dp_addr_r;
  wire ap_take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= '0;
    end
    else
    begin
      dp_wr_r <= ap_take & hwrite;
      dp_addr_r <= haddr[11:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Write strobes in the data phase
  wire wr_ctrl = dp_wr_r & (dp_addr_r == `MTIL_OFF_CTRL);
  wire wr_track = dp_wr_r & (dp_addr_r == `MTIL_OFF_TRACK);
  wire wr_clamp = dp_wr_r & (dp_addr_r == `MTIL_OFF_CLAMP);
  wire wr_mat_rg = dp_wr_r & (dp_addr_r == `MTIL_OFF_MAT_RG);
  wire wr_mat_ba = dp_wr_r & (dp_addr_r == `MTIL_OFF_MAT_BA);
  wire wr_mat_cmd = dp_wr_r & (dp_addr_r == `MTIL_OFF_MAT_CMD);
  wire wr_idx_a = dp_wr_r & (dp_addr_r == `MTIL_OFF_IDX_A);
  wire wr_idx_d = dp_wr_r & (dp_addr_r == `MTIL_OFF_IDX_D);
  wire wr_idx_s = dp_wr_r & (dp_addr_r == `MTIL_OFF_IDX_S);
  wire wr_idx_cmd = dp_wr_r & (dp_addr_r == `MTIL_OFF_IDX_CMD);

  // Lighting state
  logic [31:0] ctrl_r;
  logic [4:0] track_r;
  mtil_clamp_e clamp_r;
  logic [63:0] stage_r;
  logic [31:0] idx_stage_r [3];
  logic [31:0] idx_mat_r [2][3];
  logic [63:0] cur_color_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r <= `MTIL_CTRL_RESET;
      track_r <= `MTIL_TRACK_RESET;
      clamp_r <= MTIL_CLAMP_TRUE;
      stage_r <= '0;
      cur_color_r <= `MTIL_MAT_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= hwdata & {{(24-NLIGHTS){1'b0}}, {NLIGHTS{1'b1}}, 8'h0F};
      if (wr_track && (hwdata[1:0] != 2'h0) && (hwdata[4:2] <= 3'h4))
        track_r <= hwdata[4:0];
      if (wr_clamp && (hwdata[1:0] != 2'h3))
        clamp_r <= mtil_clamp_e'(hwdata[1:0]);
      if (wr_mat_rg)
        stage_r[31:0] <= hwdata;
      if (wr_mat_ba)
        stage_r[63:32] <= hwdata;
      if (color_valid)
        cur_color_r <= color_rgba;
    end
  end

  // Index triple, committed together per face
  genvar f;
  genvar p;
  genvar l;
  generate
    for (f = 0; f < 2; f++)
    begin : g_idx
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          idx_mat_r[f][0] <= `MTIL_IDX_A_RESET;
          idx_mat_r[f][1] <= `MTIL_IDX_D_RESET;
          idx_mat_r[f][2] <= `MTIL_IDX_S_RESET;
        end
        else if (wr_idx_cmd && hwdata[f])
        begin
          idx_mat_r[f][0] <= idx_stage_r[0];
          idx_mat_r[f][1] <= idx_stage_r[1];
          idx_mat_r[f][2] <= idx_stage_r[2];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idx_stage_r[0] <= `MTIL_IDX_A_RESET;
      idx_stage_r[1] <= `MTIL_IDX_D_RESET;
      idx_stage_r[2] <= `MTIL_IDX_S_RESET;
    end
    else
    begin
      if (wr_idx_a)
        idx_stage_r[0] <= hwdata;
      if (wr_idx_d)
        idx_stage_r[1] <= hwdata;
      if (wr_idx_s)
        idx_stage_r[2] <= hwdata;
    end
  end

  // Tracking inputs as they stand this cycle
  function automatic logic prop_hit(input logic [2:0] sel, input int unsigned pr);
    return (sel == 3'(pr)) || ((sel == MTIL_PROP_AMB_DIFF) && (pr == 1 || pr == 2));
  endfunction

  wire track_on = ctrl_r[`MTIL_CTRL_TRACK];
  wire track_on_eff = wr_ctrl ? hwdata[`MTIL_CTRL_TRACK] : track_on;
  wire track_rise = track_on_eff & ~track_on;
  wire sel_ok = (hwdata[1:0] != 2'h0) && (hwdata[4:2] <= 3'h4);
  wire [4:0] track_eff = (wr_track && sel_ok) ? hwdata[4:0] : track_r;
  wire track_load = track_on_eff & (color_valid | (wr_track & sel_ok) | track_rise);
  wire [63:0] track_src = color_valid ? color_rgba : cur_color_r;
  wire [2:0] cmd_prop = hwdata[`MTIL_SEL_PROP_LSB +: 3];

  // Materials [front, back][emission, ambient, diffuse, specular]
  logic [63:0] mat_r [2][4];
  generate
    for (f = 0; f < 2; f++)
    begin : g_face
      for (p = 0; p < 4; p++)
      begin : g_prop
        wire trk_w = track_load & track_eff[f] & prop_hit(track_eff[4:2], p);
        wire held_w = track_on & track_r[f] & prop_hit(track_r[4:2], p);
        wire exp_w = wr_mat_cmd & hwdata[`MTIL_SEL_FACE_LSB + f] & prop_hit(cmd_prop, p);
        always_ff @(posedge hclk or negedge hresetn)
        begin
          if (!hresetn)
            mat_r[f][p] <= `MTIL_MAT_RESET;
          else if (trk_w)
            mat_r[f][p] <= track_src;
          else if (exp_w && !held_w)
            mat_r[f][p] <= stage_r;
        end
        assign material_q[(f*4+p)*64 +: 64] = mat_r[f][p];
      end
    end
  endgenerate

  // Light words: diffuse {G,R}, diffuse B, specular {G,R}, specular B
  logic [31:0] light_r [NLIGHTS][4];
  logic [NLIGHTS*16-1:0] diff_int;
  logic [NLIGHTS*16-1:0] spec_int;
  generate
    for (l = 0; l < NLIGHTS; l++)
    begin : g_light
      wire hit_w = dp_wr_r
                   & (dp_addr_r[11:4] == 8'((`MTIL_OFF_LIGHT >> 4) + l));
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          light_r[l] <= '{default: 32'h0000_0000};
        else if (hit_w)
          light_r[l][dp_addr_r[3:2]] <= hwdata;
      end
      wire signed [33:0] dsum_w = 34'(signed'(light_r[l][0][15:0])) * 34'(`MTIL_W_R)
                                + 34'(signed'(light_r[l][0][31:16])) * 34'(`MTIL_W_G)
                                + 34'(signed'(light_r[l][1][15:0])) * 34'(`MTIL_W_B);
      wire signed [33:0] ssum_w = 34'(signed'(light_r[l][2][15:0])) * 34'(`MTIL_W_R)
                                + 34'(signed'(light_r[l][2][31:16])) * 34'(`MTIL_W_G)
                                + 34'(signed'(light_r[l][3][15:0])) * 34'(`MTIL_W_B);
      assign diff_int[l*16 +: 16] = dsum_w[23:8];
      assign spec_int[l*16 +: 16] = ssum_w[23:8];
    end
  endgenerate

  // Index lighting, front with N and back with -N
  wire [NLIGHTS-1:0] light_on_w = ctrl_r[`MTIL_CTRL_LEN_LSB +: NLIGHTS];
  wire two_side = ctrl_r[`MTIL_CTRL_TWO_SIDE];
  logic [NLIGHTS*16-1:0] n_dot_vp_neg;
  generate
    for (l = 0; l < NLIGHTS; l++)
    begin : g_neg
      assign n_dot_vp_neg[l*16 +: 16] = 16'(-signed'(n_dot_vp[l*16 +: 16]));
    end
  endgenerate

  logic [IDX_BITS+IDX_FRAC-1:0] idx_back_w;

  mtil_index_light #(.NLIGHTS(NLIGHTS), .IDX_BITS(IDX_BITS), .IDX_FRAC(IDX_FRAC)) u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(vtx_valid),
    .light_on(light_on_w),
    .att_spot(att_spot),
    .n_dot_vp(n_dot_vp),
    .n_dot_h_pow(n_dot_h_pow_front),
    .diff_int(diff_int),
    .spec_int(spec_int),
    .idx_a(idx_mat_r[0][0]),
    .idx_d(idx_mat_r[0][1]),
    .idx_s(idx_mat_r[0][2]),
    .idx_out(out_index_front)
  );

  mtil_index_light #(.NLIGHTS(NLIGHTS), .IDX_BITS(IDX_BITS), .IDX_FRAC(IDX_FRAC)) u_back (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(vtx_valid & two_side),
    .light_on(light_on_w),
    .att_spot(att_spot),
    .n_dot_vp(n_dot_vp_neg),
    .n_dot_h_pow(n_dot_h_pow_back),
    .diff_int(diff_int),
    .spec_int(spec_int),
    .idx_a(idx_mat_r[1][0]),
    .idx_d(idx_mat_r[1][1]),
    .idx_s(idx_mat_r[1][2]),
    .idx_out(idx_back_w)
  );

  logic two_side_q_r;
  assign out_index_back = two_side_q_r ? idx_back_w : out_index_front;

  // RGBA clamp; FIXED_ONLY clamps for a fixed-point buffer
  wire clamp_on = (clamp_r == MTIL_CLAMP_TRUE)
                  | ((clamp_r == MTIL_CLAMP_FIXED_ONLY) & FIXED_BUFFER);
  logic [63:0] pri_nxt;
  logic [63:0] sec_nxt;
  generate
    for (p = 0; p < 4; p++)
    begin : g_clamp
      wire signed [15:0] pc_w = lit_primary[p*16 +: 16];
      wire signed [15:0] sc_w = lit_secondary[p*16 +: 16];
      wire signed [15:0] one_w = `MTIL_ONE16;
      assign pri_nxt[p*16 +: 16] = !clamp_on ? pc_w : (pc_w < 0) ? 16'h0000
                                   : (pc_w > one_w) ? one_w : pc_w;
      assign sec_nxt[p*16 +: 16] = !clamp_on ? sc_w : (sc_w < 0) ? 16'h0000
                                   : (sc_w > one_w) ? one_w : sc_w;
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_valid <= 1'b0;
      out_primary <= '0;
      out_secondary <= '0;
      two_side_q_r <= 1'b0;
    end
    else
    begin
      out_valid <= vtx_valid;
      if (vtx_valid)
      begin
        out_primary <= pri_nxt;
        out_secondary <= sec_nxt;
        two_side_q_r <= two_side;
      end
    end
  end

  assign lighting_on = ctrl_r[`MTIL_CTRL_LIGHTING];
  assign index_mode = ctrl_r[`MTIL_CTRL_INDEX_MODE];

  // Read data, sampled in the address phase
  wire [11:0] ra = haddr[11:0];
  wire [3:0] rl = 4'(ra[7:4] - 4'h4);
  logic [31:0] rdata_nxt;
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (ra == `MTIL_OFF_CTRL)
      rdata_nxt = ctrl_r;
    else if (ra == `MTIL_OFF_TRACK)
      rdata_nxt = {27'h0, track_r};
    else if (ra == `MTIL_OFF_CLAMP)
      rdata_nxt = {30'h0, clamp_r};
    else if (ra == `MTIL_OFF_MAT_RG)
      rdata_nxt = stage_r[31:0];
    else if (ra == `MTIL_OFF_MAT_BA)
      rdata_nxt = stage_r[63:32];
    else if (ra == `MTIL_OFF_IDX_A)
      rdata_nxt = idx_stage_r[0];
    else if (ra == `MTIL_OFF_IDX_D)
      rdata_nxt = idx_stage_r[1];
    else if (ra == `MTIL_OFF_IDX_S)
      rdata_nxt = idx_stage_r[2];
    else if (ra == `MTIL_OFF_IDX_OUT)
      rdata_nxt = {16'(out_index_back), 16'(out_index_front)};
    else if ((ra >= `MTIL_OFF_LIGHT) && (32'(rl) < NLIGHTS) && (ra[1:0] == 2'h0))
      rdata_nxt = light_r[rl[2:0]][ra[3:2]];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (ap_take && !hwrite)
      hrdata <= rdata_nxt;
  end

endmodule

// ---- verilog/mtil_defs.svh ----
// Block constants and behaviour rules
// Behaviour
// - While tracking, selected materials follow each new colour.
// - Tracking face is front, back or both.
// - One property each; ambient-plus-diffuse drives both.
// - Tracked values persist; writes to overridden properties drop.
// - New selection while tracking loads the colour at once.
// - Eight lights with enables, two-sided, lighting, tracking bits.
// - Reset clears flags, selects both/ambient-plus-diffuse, defaults.
// - Index intensities are .30 R + .59 G + .11 B.
// - Index is am + d(1-s')(dm-am) + s'(sm-am), s' = min(s,1).
// - Final index is min of that and specular index.
// - Disabled lights drop out of both sums.
// - Index triple resets 0,1,1, written together.
// - Two-sided gives separate front and back indices.
// - Clamping limits primary and secondary to [0,1].
// - Index rounds to fixed point; integer ANDed with 2^n-1.
// - Clamp control is three-valued, resets to enabled.
// - Sums use attenuation and spot terms with RGB intensities; facing only for nonzero N.VP.
`ifndef MTIL_DEFS_SVH
`define MTIL_DEFS_SVH

// Register byte offsets
`define MTIL_OFF_CTRL 12'h000
`define MTIL_OFF_TRACK 12'h004
`define MTIL_OFF_CLAMP 12'h008
`define MTIL_OFF_MAT_RG 12'h010
`define MTIL_OFF_MAT_BA 12'h014
`define MTIL_OFF_MAT_CMD 12'h018
`define MTIL_OFF_IDX_A 12'h020
`define MTIL_OFF_IDX_D 12'h024
`define MTIL_OFF_IDX_S 12'h028
`define MTIL_OFF_IDX_CMD 12'h02C
`define MTIL_OFF_IDX_OUT 12'h030
`define MTIL_OFF_LIGHT 12'h040
`define MTIL_LIGHT_STRIDE 12'h010

// Control register fields
`define MTIL_CTRL_LIGHTING 0
`define MTIL_CTRL_TWO_SIDE 1
`define MTIL_CTRL_TRACK 2
`define MTIL_CTRL_INDEX_MODE 3
`define MTIL_CTRL_LEN_LSB 8
`define MTIL_CTRL_RESET 32'h0000_0000

// Selection fields
`define MTIL_SEL_FACE_LSB 0
`define MTIL_SEL_PROP_LSB 2
`define MTIL_TRACK_RESET 5'h13

// Fixed point: 12 fractional bits, 1.0 = 0x1000
`define MTIL_FRAC 12
`define MTIL_ONE 32'h0000_1000
`define MTIL_ONE16 16'h1000
`define MTIL_MAT_RESET 64'h1000_0000_0000_0000
`define MTIL_IDX_A_RESET 32'h0000_0000
`define MTIL_IDX_D_RESET 32'h0000_1000
`define MTIL_IDX_S_RESET 32'h0000_1000

// Luma weights over 256: .30, .59, .11
`define MTIL_W_R 18'h0004D
`define MTIL_W_G 18'h00097
`define MTIL_W_B 18'h0001C

`endif

// ---- verilog/mtil_pkg.sv ----
// Types of the lighting block
package mtil_pkg;

  typedef enum logic [1:0] {
    MTIL_FACE_FRONT = 2'h1,
    MTIL_FACE_BACK = 2'h2,
    MTIL_FACE_BOTH = 2'h3
  } mtil_face_e;

  typedef enum logic [2:0] {
    MTIL_PROP_EMISSION = 3'h0,
    MTIL_PROP_AMBIENT = 3'h1,
    MTIL_PROP_DIFFUSE = 3'h2,
    MTIL_PROP_SPECULAR = 3'h3,
    MTIL_PROP_AMB_DIFF = 3'h4
  } mtil_prop_e;

  typedef enum logic [1:0] {
    MTIL_CLAMP_FALSE = 2'h0,
    MTIL_CLAMP_TRUE = 2'h1,
    MTIL_CLAMP_FIXED_ONLY = 2'h2
  } mtil_clamp_e;

endpackage

// ---- verilog/mtil_index_light.sv ----
// Index lighting of one face, with rounding and mask
`timescale 1ns/1ps
`include "mtil_defs.svh"
module mtil_index_light
  import mtil_pkg::*;
#(
  parameter int NLIGHTS = 8,
  parameter int IDX_BITS = 8,
  parameter int IDX_FRAC = 4
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Per-vertex terms
  input wire logic in_valid,
  input wire logic [NLIGHTS-1:0] light_on,
  input wire logic [NLIGHTS*16-1:0] att_spot,
  input wire logic [NLIGHTS*16-1:0] n_dot_vp,
  input wire logic [NLIGHTS*16-1:0] n_dot_h_pow,
  input wire logic [NLIGHTS*16-1:0] diff_int,
  input wire logic [NLIGHTS*16-1:0] spec_int,
  // Index material
  input wire logic [31:0] idx_a,
  input wire logic [31:0] idx_d,
  input wire logic [31:0] idx_s,
  // Result
  output logic [IDX_BITS+IDX_FRAC-1:0] idx_out
);

  function automatic logic signed [31:0] mulq(input logic signed [31:0] a,
                                              input logic signed [31:0] b);
    logic signed [63:0] p;
    p = a * b;
    return p[43:12];
  endfunction

  logic signed [31:0] d_term [NLIGHTS];
  logic signed [31:0] s_term [NLIGHTS];

  genvar l;
  generate
    for (l = 0; l < NLIGHTS; l++)
    begin : g_term
      wire signed [31:0] as_w = 32'(signed'(att_spot[l*16 +: 16]));
      wire signed [31:0] nvp_w = 32'(signed'(n_dot_vp[l*16 +: 16]));
      wire signed [31:0] nh_w = 32'(signed'(n_dot_h_pow[l*16 +: 16]));
      wire signed [31:0] dl_w = 32'(signed'(diff_int[l*16 +: 16]));
      wire signed [31:0] sl_w = 32'(signed'(spec_int[l*16 +: 16]));
      wire facing_w = (nvp_w != 32'h0000_0000);
      assign d_term[l] = light_on[l] ? mulq(mulq(as_w, dl_w), nvp_w) : '0;
      assign s_term[l] = (light_on[l] && facing_w) ? mulq(mulq(as_w, sl_w), nh_w) : '0;
    end
  endgenerate

  logic signed [31:0] d_sum;
  logic signed [31:0] s_sum;
  always_comb
  begin
    d_sum = '0;
    s_sum = '0;
    for (int i = 0; i < NLIGHTS; i++)
    begin
      d_sum = d_sum + d_term[i];
      s_sum = s_sum + s_term[i];
    end
  end

  localparam logic signed [31:0] ONE = `MTIL_ONE;
  localparam logic signed [31:0] HALF = 32'(1 << (`MTIL_FRAC - IDX_FRAC - 1));
  localparam logic [31:0] INT_MASK = 32'((1 << IDX_BITS) - 1);

  wire signed [31:0] s_clip = (s_sum > ONE) ? ONE : s_sum;
  wire signed [31:0] a_w = idx_a;
  wire signed [31:0] dm_w = idx_d;
  wire signed [31:0] sm_w = idx_s;
  wire signed [31:0] c_w = a_w + mulq(mulq(d_sum, ONE - s_clip), dm_w - a_w)
                           + mulq(s_clip, sm_w - a_w);
  wire signed [31:0] c_min = (c_w < sm_w) ? c_w : sm_w;
  wire signed [31:0] rnd_w = (c_min + HALF) >>> (`MTIL_FRAC - IDX_FRAC);
  wire [31:0] int_w = (32'(rnd_w) >> IDX_FRAC) & INT_MASK;
  wire [IDX_BITS+IDX_FRAC-1:0] idx_nxt = {int_w[IDX_BITS-1:0], rnd_w[IDX_FRAC-1:0]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      idx_out <= '0;
    else if (in_valid)
      idx_out <= idx_nxt;
  end

endmodule

// ---- dv/mtil_top_sva.sv ----
// Port checker of the lighting block
`timescale 1ns/1ps
module mtil_top_sva
(
  // Clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Colour and vertex path
  input wire logic color_valid,
  input wire logic [63:0] color_rgba,
  input wire logic vtx_valid,
  input wire logic [63:0] lit_primary,
  input wire logic [63:0] lit_secondary,
  input wire logic out_valid,
  input wire logic [63:0] out_primary,
  input wire logic [63:0] out_secondary,
  input wire logic [11:0] out_index_front,
  input wire logic [511:0] material_q
);
  logic wr_dp_r;

  // Write data-phase edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_dp_r <= 1'b0;
    else if (hready)
      wr_dp_r <= hsel && htrans[1] && hwrite;
  end

  function automatic logic [63:0] clampv(logic [63:0] v);
    clampv = v;
    for (int k = 0; k < 4; k++)
      if ($signed(v[16*k+:16]) < 0)
        clampv[16*k+:16] = 16'h0000;
      else if ($signed(v[16*k+:16]) > 16'sh1000)
        clampv[16*k+:16] = 16'h1000;
  endfunction

  function automatic logic trk_ok(logic [511:0] m, logic [511:0] p, logic [63:0] c);
    trk_ok = 1'b1;
    for (int k = 0; k < 8; k++)
      if (m[64*k+:64] != p[64*k+:64] && m[64*k+:64] != c)
        trk_ok = 1'b0;
  endfunction

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  track_copy_a: assert property (color_valid && !wr_dp_r |=>
    trk_ok(material_q, $past(material_q), $past(color_rgba))) else $error("tracked copy wrong");
  mat_hold_a: assert property (!color_valid && !wr_dp_r |=> $stable(material_q))
    else $error("material changed without cause");
  out_next_a: assert property (vtx_valid |=> out_valid)
    else $error("no result after vertex");
  out_cause_a: assert property (out_valid |-> $past(vtx_valid))
    else $error("result without vertex");
  clamp_pass_a: assert property (vtx_valid |=>
    (out_primary == $past(lit_primary) || out_primary == clampv($past(lit_primary))) &&
    (out_secondary == $past(lit_secondary) || out_secondary == clampv($past(lit_secondary))))
    else $error("colour neither clamped nor passed");
  out_hold_a: assert property (!vtx_valid |=> $stable(out_primary) &&
    $stable(out_index_front)) else $error("result moved between vertices");
  ready_high_a: assert property (hreadyout) else $error("wait state inserted");
  okay_resp_a: assert property (!hresp) else $error("error response");

  cover property (color_valid && !wr_dp_r);
  cover property (vtx_valid ##1 out_valid);
  cover property (wr_dp_r);
endmodule

bind mtil_top mtil_top_sva u_sva (.*);

// ---- dv/mtil_feed.sv ----
// Upstream colour source model
`timescale 1ns/1ps
module mtil_feed
(
  // Clock
  input wire logic hclk,
  // Current colour
  output logic color_valid,
  output logic [63:0] color_rgba
);
  initial
  begin
    color_valid = 1'b0;
    color_rgba = 64'h0;
  end

  // Inverse outside the pulse exposes stale latches
  task automatic send(input logic [63:0] c, input int gap);
    @(posedge hclk);
    color_valid <= 1'b1;
    color_rgba <= c;
    @(posedge hclk);
    color_valid <= 1'b0;
    color_rgba <= ~c;
    repeat (gap) @(posedge hclk);
  endtask
endmodule

// ---- dv/mtil_top_bench.sv ----
// Self-checking bench of the lighting block
`timescale 1ns/1ps
`include "mtil_defs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module mtil_top_bench;
  logic hclk, hresetn, hsel, hwrite, vtx_valid, hready, hresp, out_valid;
  logic color_valid, lighting_on, index_mode;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [63:0] color_rgba, lit_primary, lit_secondary, out_primary, out_secondary, cur, v;
  logic [127:0] att_spot, n_dot_vp, nhp_f, nhp_b;
  logic [11:0] out_index_front, out_index_back, fe, be;
  logic [511:0] material_q;
  logic [63:0] mat [8];
  logic [4:0] trk, s;
  logic [7:0] en;
  bit trk_on;
  int failures, checked, cl, two;
  longint dc [8][3], sc [8][3], ndv [8], ia [2], id [2], is [2];
  logic [11:0] ra [6] = '{`MTIL_OFF_CTRL, `MTIL_OFF_TRACK, `MTIL_OFF_CLAMP, `MTIL_OFF_MAT_CMD,
    `MTIL_OFF_IDX_OUT, 12'h3FC};
  logic [31:0] rv [6] = '{32'h0, 32'h13, 32'h1, 32'h0, 32'h0, 32'h0};

  mtil_feed u_feed (.hclk(hclk), .color_valid(color_valid), .color_rgba(color_rgba));
  mtil_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .color_valid(color_valid), .color_rgba(color_rgba),
    .vtx_valid(vtx_valid), .att_spot(att_spot), .n_dot_vp(n_dot_vp),
    .n_dot_h_pow_front(nhp_f), .n_dot_h_pow_back(nhp_b), .lit_primary(lit_primary),
    .lit_secondary(lit_secondary), .out_valid(out_valid), .out_primary(out_primary),
    .out_secondary(out_secondary), .out_index_front(out_index_front),
    .out_index_back(out_index_back), .material_q(material_q), .lighting_on(lighting_on),
    .index_mode(index_mode));

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    if (n >= 50)
      failures++;
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    #1;
  endtask

  function automatic logic [511:0] mq();
    for (int k = 0; k < 8; k++)
      mq[64*k+:64] = mat[k];
  endfunction

  function automatic bit hit(int f, int p, logic [4:0] sl);
    return sl[f] && (sl[4:2] == p || (sl[4:2] == 3'h4 && (p == 1 || p == 2)));
  endfunction

  // Explicit writes skip tracked properties
  task automatic load(logic [63:0] c, logic [4:0] sl, bit xp);
    for (int k = 0; k < 8; k++)
      if (hit(k / 4, k % 4, sl) && !(xp && trk_on && hit(k / 4, k % 4, trk)))
        mat[k] = c;
  endtask

  task automatic col(logic [63:0] c);
    u_feed.send(c, $urandom_range(0, 2));
    cur = c;
    if (trk_on)
      load(c, trk, 1'b0);
    #1;
    `CHK("material colour", mq(), material_q)
  endtask

  function automatic logic [63:0] clamp64(logic [63:0] c);
    clamp64 = c;
    for (int k = 0; k < 4; k++)
      if (cl != 0 && $signed(c[16*k+:16]) < 0)
        clamp64[16*k+:16] = 16'h0000;
      else if (cl != 0 && $signed(c[16*k+:16]) > 16'sh1000)
        clamp64[16*k+:16] = 16'h1000;
  endfunction

  function automatic logic [11:0] idx_model(int b);
    longint d, sp, c, nd;
    d = 0;
    sp = 0;
    for (int i = 0; i < 8; i++)
      if (en[i])
      begin
        nd = b ? -ndv[i] : ndv[i];
        d += (((dc[i][0] * 77 + dc[i][1] * 151 + dc[i][2] * 28) >>> 8) * nd) >>> 12;
        if (nd != 0)
          sp += (sc[i][0] * 77 + sc[i][1] * 151 + sc[i][2] * 28) >>> 8;
      end
    if (sp > 4096)
      sp = 4096;
    c = ia[b] + ((((d * (4096 - sp)) >>> 12) * (id[b] - ia[b])) >>> 12);
    c += (sp * (is[b] - ia[b])) >>> 12;
    if (c > is[b])
      c = is[b];
    return 12'((c + 128) >>> 8);
  endfunction

  task automatic vtx();
    @(posedge hclk);
    vtx_valid <= 1'b1;
    lit_primary <= {$urandom, $urandom};
    lit_secondary <= {$urandom, $urandom};
    for (int i = 0; i < 8; i++)
    begin
      att_spot[16*i+:16] <= en[i] ? 16'h1000 : 16'($urandom);
      n_dot_vp[16*i+:16] <= 16'(ndv[i]);
      nhp_f[16*i+:16] <= en[i] ? 16'h1000 : 16'($urandom);
      nhp_b[16*i+:16] <= en[i] ? 16'h1000 : 16'($urandom);
    end
    @(posedge hclk);
    vtx_valid <= 1'b0;
    #1;
    fe = idx_model(0);
    be = two ? idx_model(1) : fe;
    `CHK("out valid", 1'b1, out_valid)
    `CHK("primary", clamp64(lit_primary), out_primary)
    `CHK("secondary", clamp64(lit_secondary), out_secondary)
    `CHK("index front", fe, out_index_front)
    `CHK("index back", be, out_index_back)
  endtask

  initial
  begin
    {hsel, hwrite, vtx_valid, hresetn} = 4'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    {lit_primary, lit_secondary} = 128'h0;
    {att_spot, n_dot_vp, nhp_f, nhp_b} = 512'h0;
    void'($urandom(42));
    trk = 5'h13;
    cl = 1;
    foreach (mat[k])
      mat[k] = `MTIL_MAT_RESET;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK("material reset", mq(), material_q)
    foreach (ra[k])
    begin
      bus(1'b0, ra[k], 32'h0);
      `CHK("reset register", rv[k], rd)
    end
    col({$urandom, $urandom});
    bus(1'b1, `MTIL_OFF_CTRL, 32'h4);
    trk_on = 1'b1;
    load(cur, trk, 1'b0);
    `CHK("material enable", mq(), material_q)
    for (int k = 0; k < 15; k++)
    begin
      s = {3'(k % 5), 2'(k / 5 + 1)};
      bus(1'b1, `MTIL_OFF_TRACK, {27'h0, s});
      trk = s;
      load(cur, trk, 1'b0);
      `CHK("material select", mq(), material_q)
      col({$urandom, $urandom});
      v = {$urandom, $urandom};
      bus(1'b1, `MTIL_OFF_MAT_RG, v[31:0]);
      bus(1'b1, `MTIL_OFF_MAT_BA, v[63:32]);
      bus(1'b1, `MTIL_OFF_MAT_CMD, {27'h0, 3'(4 - k % 5), 2'h3});
      load(v, {3'(4 - k % 5), 2'h3}, 1'b1);
      `CHK("material write", mq(), material_q)
    end
    bus(1'b1, `MTIL_OFF_TRACK, 32'h10);
    bus(1'b1, `MTIL_OFF_TRACK, 32'h15);
    bus(1'b0, `MTIL_OFF_TRACK, 32'h0);
    `CHK("track refused", {27'h0, trk}, rd)
    bus(1'b1, `MTIL_OFF_CTRL, 32'h0);
    trk_on = 1'b0;
    col({$urandom, $urandom});
    bus(1'b1, `MTIL_OFF_MAT_CMD, {27'h0, trk});
    load(v, trk, 1'b1);
    `CHK("material untracked", mq(), material_q)
    for (int it = 0; it < 12; it++)
    begin
      en = 8'($urandom);
      two = it % 2;
      for (int i = 0; i < 8; i++)
      begin
        for (int j = 0; j < 3; j++)
        begin
          dc[i][j] = $urandom_range(0, 4096);
          sc[i][j] = (it % 3 == 2) ? 4096 : 0;
        end
        ndv[i] = ($urandom_range(0, 3) == 0) ? 0 : $urandom_range(1, 4096);
        bus(1'b1, 12'h040 + 12'(16 * i), {16'(dc[i][1]), 16'(dc[i][0])});
        bus(1'b1, 12'h044 + 12'(16 * i), 32'(dc[i][2]));
        bus(1'b1, 12'h048 + 12'(16 * i), {16'(sc[i][1]), 16'(sc[i][0])});
        bus(1'b1, 12'h04C + 12'(16 * i), 32'(sc[i][2]));
      end
      for (int f = 0; f < 2; f++)
      begin
        ia[f] = $urandom_range(0, 16384);
        id[f] = $urandom_range(0, 262144);
        is[f] = $urandom_range(0, 2097152);
        bus(1'b1, `MTIL_OFF_IDX_A, 32'(ia[f]));
        bus(1'b1, `MTIL_OFF_IDX_D, 32'(id[f]));
        bus(1'b1, `MTIL_OFF_IDX_S, 32'(is[f]));
        bus(1'b1, `MTIL_OFF_IDX_CMD, 32'(f + 1));
      end
      bus(1'b1, `MTIL_OFF_CTRL, {16'h0, en, 5'h1, 1'b0, 1'(two), 1'b1});
      `CHK("index mode", 1'b1, index_mode)
      `CHK("lighting", 1'b1, lighting_on)
      v[1:0] = 2'($urandom_range(0, 3));
      bus(1'b1, `MTIL_OFF_CLAMP, {30'h0, v[1:0]});
      if (v[1:0] != 2'h3)
        cl = v[1:0];
      bus(1'b0, `MTIL_OFF_CLAMP, 32'h0);
      `CHK("clamp control", 32'(cl), rd)
      vtx();
      vtx();
      bus(1'b0, `MTIL_OFF_IDX_OUT, 32'h0);
      `CHK("index readback", {4'h0, be, 4'h0, fe}, rd)
    end
    final_report();
  end

  initial
  begin
    #400000;
    failures++;
    final_report();
  end
endmodule
